// ==== include/rcs_pkg.sv ====
// Shared constants and types for the reset, strap and speaker support block
`default_nettype none
package rcs_pkg;

	// Register map: printed port index kept, byte address is four times it
	localparam logic [9:0] RCS_CTRL_INDEX = 10'h061;
	localparam logic [9:0] RCS_STATUS_INDEX = 10'h062;
	localparam logic [11:0] RCS_CTRL_ADDR = {RCS_CTRL_INDEX, 2'b00};
	localparam logic [11:0] RCS_STATUS_ADDR = {RCS_STATUS_INDEX, 2'b00};

	// Control register fields
	localparam int RCS_SPK_EN_BIT = 1;
	localparam logic [31:0] RCS_CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int RCS_ST_PG_BIT = 0;
	localparam int RCS_ST_RUN_BIT = 1;
	localparam int RCS_ST_CPU_TYPE_BIT = 2;
	localparam int RCS_ST_BOOT_BIT = 3;
	localparam int RCS_ST_TEST_N_BIT = 4;
	localparam int RCS_ST_SPK_BIT = 5;

	// Boot window: top 64 Kbytes from ffff0000
	localparam logic [15:0] RCS_BOOT_PAGE = 16'hffff;

	// Consecutive high samples of power good before reset is released
	localparam logic [1:0] RCS_PG_QUAL_CYCLES = 2'h2;

	// AXI responses
	localparam logic [1:0] RCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCS_RESP_SLVERR = 2'h2;

	// Synchronised pin bundle
	typedef struct packed {
		logic test_mode_n;
		logic boot_decode;
		logic cpu_type;
		logic power_good;
	} rcs_pins_type;

	// Reset sequencer states, Gray along the path
	typedef enum logic [1:0] {
		RCS_HOLD = 2'b00,
		RCS_QUAL = 2'b01,
		RCS_RUN = 2'b11
	} rcs_state_type;

endpackage

`default_nettype wire

// ==== hdl/rcs_sync.sv ====
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module rcs_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	// First stage is read only by the second
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
		if (!aresetn) begin
			next_stage1 = '0;
			next_sync_out = '0;
		end
	end

	always_ff @(posedge aclk) begin
		stage1 <= next_stage1;
		sync_out <= next_sync_out;
	end

endmodule

`default_nettype wire

// ==== hdl/rcs_top.sv ====
// Reset sequencing, strap handling, boot decode and speaker gate with AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Processor-type strap: low first family, high later; sets reset and init polarity, but its synchroniser reads low in bus reset, giving first-family polarity.
// - Boot strap low: positive decode of top 64 KB; high: subtractive claim only.
// - Power good low holds PCI and ISA resets asserted; CPU reset too, except for the later family in and just after bus reset.
// - Power good high releases CPU, PCI and ISA resets.
// - Speaker is timer counter 2 ANDed with speaker enable, port 061h bit 1.
// - Speaker low in and after reset, holds last value in power-on suspend.
module rcs_top
	import rcs_pkg::*;
(
	// Clock and bus reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Asynchronous pins
	input wire logic power_good_in,
	input wire logic cpu_type_strap,
	input wire logic boot_decode_strap,
	input wire logic test_mode_n,
	// Same-clock logic inputs
	input wire logic timer2_out,
	input wire logic suspend_pos,
	input wire logic init_request,
	input wire logic [31:0] mem_addr,
	input wire logic mem_cycle_valid,
	// Reset and init outputs
	output logic cpu_reset_out,
	output logic cpu_init_out,
	output logic pci_reset_out_n,
	output logic isa_reset_drive_out,
	// Boot decode claims
	output logic boot_positive_claim,
	output logic boot_subtractive_claim,
	// Speaker
	output logic speaker_out
);

	rcs_pins_type pins;
	rcs_state_type state, next_state;
	logic [1:0] pg_count, next_pg_count;
	logic [31:0] ctrl, next_ctrl;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_cpu_reset_out, next_cpu_init_out, next_pci_reset_out_n, next_isa_reset_drive_out;
	logic next_boot_positive_claim, next_boot_subtractive_claim, next_speaker_out;
	logic in_reset;
	logic [31:0] status;

	// All pins cross into the clock domain before any logic sees them
	rcs_sync #(
		.WIDTH(4)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({test_mode_n, boot_decode_strap, cpu_type_strap, power_good_in}),
		.sync_out(pins)
	);

	// Power-good qualification; any low sample restarts it, so a glitch cannot release reset
	always_comb begin
		next_state = state;
		next_pg_count = pg_count;
		case (state)
			RCS_HOLD: begin
				next_pg_count = 2'h0;
				if (pins.power_good) begin
					next_state = RCS_QUAL;
					next_pg_count = 2'h1;
				end
			end
			RCS_QUAL: begin
				if (!pins.power_good) begin
					next_state = RCS_HOLD;
					next_pg_count = 2'h0;
				end else if (pg_count + 2'h1 >= RCS_PG_QUAL_CYCLES) begin
					next_state = RCS_RUN;
				end else begin
					next_pg_count = pg_count + 2'h1;
				end
			end
			RCS_RUN: begin
				if (!pins.power_good) begin
					next_state = RCS_HOLD;
					next_pg_count = 2'h0;
				end
			end
			default: begin
				next_state = RCS_HOLD;
				next_pg_count = 2'h0;
			end
		endcase
		if (!aresetn) begin
			next_state = RCS_HOLD;
			next_pg_count = 2'h0;
		end
	end

	always_ff @(posedge aclk) begin
		state <= next_state;
		pg_count <= next_pg_count;
	end

	assign in_reset = (state != RCS_RUN);

	// Reset, init, decode and speaker outputs, all registered
	always_comb begin
		// Later family takes active-low reset and init, first family active-high
		next_cpu_reset_out = pins.cpu_type ? (next_state == RCS_RUN) : (next_state != RCS_RUN);
		next_cpu_init_out = pins.cpu_type ? ~init_request : init_request;
		next_pci_reset_out_n = (next_state == RCS_RUN);
		next_isa_reset_drive_out = (next_state != RCS_RUN);
		// Strap is only sampled, board keeps it static
		next_boot_positive_claim = mem_cycle_valid && (mem_addr[31:16] == RCS_BOOT_PAGE)
			&& !pins.boot_decode;
		next_boot_subtractive_claim = mem_cycle_valid && (mem_addr[31:16] == RCS_BOOT_PAGE)
			&& pins.boot_decode;
		if (next_state != RCS_RUN) begin // Silenced on the same edge as the reset outputs
			next_speaker_out = 1'b0;
		end else if (suspend_pos) begin
			next_speaker_out = speaker_out;
		end else begin
			next_speaker_out = timer2_out & ctrl[RCS_SPK_EN_BIT];
		end
		if (!aresetn) begin
			next_cpu_init_out = pins.cpu_type;
			next_boot_positive_claim = 1'b0;
			next_boot_subtractive_claim = 1'b0;
			next_speaker_out = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		cpu_reset_out <= next_cpu_reset_out;
		cpu_init_out <= next_cpu_init_out;
		pci_reset_out_n <= next_pci_reset_out_n;
		isa_reset_drive_out <= next_isa_reset_drive_out;
		boot_positive_claim <= next_boot_positive_claim;
		boot_subtractive_claim <= next_boot_subtractive_claim;
		speaker_out <= next_speaker_out;
	end

	// Status view of the block's own state
	always_comb begin
		status = 32'h0000_0000;
		status[RCS_ST_PG_BIT] = pins.power_good;
		status[RCS_ST_RUN_BIT] = ~in_reset;
		status[RCS_ST_CPU_TYPE_BIT] = pins.cpu_type;
		status[RCS_ST_BOOT_BIT] = pins.boot_decode;
		status[RCS_ST_TEST_N_BIT] = pins.test_mode_n;
		status[RCS_ST_SPK_BIT] = speaker_out;
	end

	// Write path: address and data taken in either order, response after both
	always_comb begin
		logic have_aw;
		logic have_w;
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
		have_aw = aw_held | (awvalid & awready);
		have_w = w_held | (wvalid & wready);
		addr = aw_held ? aw_addr : awaddr;
		data = w_held ? w_data : wdata;
		strb = w_held ? w_strb : wstrb;
		next_aw_held = have_aw;
		next_w_held = have_w;
		next_aw_addr = addr;
		next_w_data = data;
		next_w_strb = strb;
		next_ctrl = ctrl;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (have_aw && have_w && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			if (addr[11:2] == RCS_CTRL_INDEX) begin
				for (int i = 0; i < 4; i++) begin
					if (strb[i]) begin
						next_ctrl[8*i +: 8] = data[8*i +: 8];
					end
				end
				next_bresp = RCS_RESP_OKAY;
			end else if (addr[11:2] == RCS_STATUS_INDEX) begin
				next_bresp = RCS_RESP_OKAY; // Status is read-only, write ignored
			end else begin
				next_bresp = RCS_RESP_SLVERR;
			end
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		if (!aresetn) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_aw_addr = 12'h000;
			next_w_data = 32'h0000_0000;
			next_w_strb = 4'h0;
			next_ctrl = RCS_CTRL_RESET;
			next_bvalid = 1'b0;
			next_bresp = RCS_RESP_OKAY;
			next_awready = 1'b0;
			next_wready = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		aw_held <= next_aw_held;
		w_held <= next_w_held;
		aw_addr <= next_aw_addr;
		w_data <= next_w_data;
		w_strb <= next_w_strb;
		ctrl <= next_ctrl;
		bvalid <= next_bvalid;
		bresp <= next_bresp;
		awready <= next_awready;
		wready <= next_wready;
	end

	// Read path: one read outstanding, answer the cycle after the address
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = RCS_RESP_OKAY;
			if (araddr[11:2] == RCS_CTRL_INDEX) begin
				next_rdata = ctrl;
			end else if (araddr[11:2] == RCS_STATUS_INDEX) begin
				next_rdata = status;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = RCS_RESP_SLVERR;
			end
		end
		next_arready = !next_rvalid;
		if (!aresetn) begin
			next_rvalid = 1'b0;
			next_rdata = 32'h0000_0000;
			next_rresp = RCS_RESP_OKAY;
			next_arready = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		rvalid <= next_rvalid;
		rdata <= next_rdata;
		rresp <= next_rresp;
		arready <= next_arready;
	end

endmodule

`default_nettype wire

// ==== bench/rcs_board.sv ====
// Board model: power supervisor, strap resistors and interval timer
`timescale 1ns/1ps
`default_nettype none
module rcs_board #(
	parameter int PG_WAIT = 4
) (
	// Clock
	input wire logic aclk,
	// Bench commands
	input wire logic pg_cmd,
	input wire logic glitch,
	input wire logic [1:0] strap_cmd,
	// Pins to the block
	output logic power_good_in,
	output logic cpu_type_strap,
	output logic boot_decode_strap,
	output logic test_mode_n,
	output logic timer2_out
);
	logic [7:0] cnt = 8'h00;
	logic pg_level = 1'h0;
	logic [1:0] div = 2'h0;
	logic tmr = 1'h0;
	// Settling count stands in for the long stable-clock wait
	always_ff @(posedge aclk) begin
		cnt <= (pg_cmd && cnt != 8'(PG_WAIT)) ? cnt + 8'h01 : (pg_cmd ? cnt : 8'h00);
		pg_level <= pg_cmd && cnt == 8'(PG_WAIT);
	end
	// Glitch breaks the supervisor timing on purpose
	assign power_good_in = pg_level | glitch;
	// Straps change only while the block is held in reset
	assign cpu_type_strap = strap_cmd[0];
	assign boot_decode_strap = strap_cmd[1];
	assign test_mode_n = 1'h1;
	// Counter 2 square wave, six cycle period
	always_ff @(posedge aclk) begin
		div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
		tmr <= (div == 2'h2) ? !tmr : tmr;
	end
	assign timer2_out = tmr;
endmodule
`default_nettype wire

// ==== bench/rcs_top_chk.sv ====
// Checker for reset, strap, decode and speaker outputs
`timescale 1ns/1ps
`default_nettype none
module rcs_top_chk
	import rcs_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Inputs
	input wire logic power_good_in,
	input wire logic cpu_type_strap,
	input wire logic boot_decode_strap,
	input wire logic timer2_out,
	input wire logic suspend_pos,
	input wire logic init_request,
	input wire logic [31:0] mem_addr,
	input wire logic mem_cycle_valid,
	// Outputs
	input wire logic cpu_reset_out,
	input wire logic cpu_init_out,
	input wire logic pci_reset_out_n,
	input wire logic isa_reset_drive_out,
	input wire logic boot_positive_claim,
	input wire logic boot_subtractive_claim,
	input wire logic speaker_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Claims are registered, so compare against last cycle's hit
	logic hit_seen;
	wire logic next_hit = mem_cycle_valid && mem_addr[31:16] == RCS_BOOT_PAGE;
	always_ff @(posedge aclk) begin
		hit_seen <= next_hit;
	end
	a_resets_agree: assert property (pci_reset_out_n == !isa_reset_drive_out)
		else $error("pci and isa resets disagree");
	a_pg_low_hold: assert property (!power_good_in [*5] |-> !pci_reset_out_n)
		else $error("reset not held with power good low");
	a_pg_release: assert property (power_good_in [*7] |-> pci_reset_out_n)
		else $error("reset not released");
	a_no_glitch: assert property ($rose(pci_reset_out_n) |-> $past(power_good_in, 3) && $past(power_good_in, 4))
		else $error("release without qualified power good");
	a_cpu_pol: assert property ($stable(cpu_type_strap) [*5]
		|-> (cpu_reset_out ^ cpu_type_strap) == !pci_reset_out_n)
		else $error("cpu reset polarity wrong");
	a_init_pol: assert property ($stable(cpu_type_strap) [*5] ##0 $stable(init_request)
		|-> cpu_init_out == (init_request ^ cpu_type_strap))
		else $error("init polarity wrong");
	a_pos_claim: assert property ($stable(boot_decode_strap) [*4]
		|-> boot_positive_claim == (hit_seen && !boot_decode_strap))
		else $error("positive claim wrong");
	a_sub_claim: assert property ($stable(boot_decode_strap) [*4]
		|-> boot_subtractive_claim == (hit_seen && boot_decode_strap))
		else $error("subtractive claim wrong");
	a_spk_off: assert property (!pci_reset_out_n [*2] |-> !speaker_out)
		else $error("speaker active in reset");
	a_spk_gate: assert property ($rose(speaker_out) |-> $past(timer2_out) && !$past(suspend_pos))
		else $error("speaker rose without timer");
	a_spk_hold: assert property ($past(suspend_pos) && $past(pci_reset_out_n) && pci_reset_out_n
		|-> $stable(speaker_out))
		else $error("speaker moved in suspend");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the reset, strap, decode and speaker block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rcs_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, mem_addr = 32'h0, rdata;
	logic [1:0] bresp, rresp, strap_cmd = 2'h0;
	logic suspend_pos = 1'h0, mem_cycle_valid = 1'h0, pg_cmd = 1'h0, glitch = 1'h0, init_request = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, power_good_in, cpu_type_strap, boot_decode_strap;
	logic test_mode_n, timer2_out, cpu_reset_out, cpu_init_out, pci_reset_out_n, isa_reset_drive_out;
	logic boot_positive_claim, boot_subtractive_claim, speaker_out;
	int miscompares = 0, cmp_count = 0;
	// Clock
	always #50 aclk = ~aclk;
	rcs_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.power_good_in, .cpu_type_strap, .boot_decode_strap, .test_mode_n, .timer2_out, .suspend_pos,
		.init_request, .mem_addr, .mem_cycle_valid, .cpu_reset_out, .cpu_init_out, .pci_reset_out_n,
		.isa_reset_drive_out, .boot_positive_claim, .boot_subtractive_claim, .speaker_out);
	rcs_board board_u (.aclk, .pg_cmd, .glitch, .strap_cmd, .power_good_in, .cpu_type_strap,
		.boot_decode_strap, .test_mode_n, .timer2_out);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("Compares %0d errors %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic bound(input int n);
		if (n >= 40) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// Outputs are registers, so reading at the edge sees last cycle's result
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid && n < 40);
		r = bresp;
		bready <= 1'h0;
		bound(n);
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'h0;
		end while (!rvalid && n < 40);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		bound(n);
	endtask
	task automatic t_reset(input logic v);
		int n = 0;
		@(posedge aclk);
		aresetn <= 1'h0;
		pg_cmd <= 1'h0;
		strap_cmd <= {v, v};
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (6) @(posedge aclk);
		chk("pci_reset", pci_reset_out_n, 1'h0);
		chk("isa_reset", isa_reset_drive_out, 1'h1);
		chk("cpu_reset", cpu_reset_out, !v);
		chk("cpu_init", cpu_init_out, v);
		// Raised init must come out with the strap's polarity
		init_request <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("cpu_init_on", cpu_init_out, !v);
		init_request <= 1'h0;
		glitch <= 1'h1;
		@(posedge aclk);
		glitch <= 1'h0;
		repeat (8) @(posedge aclk);
		chk("glitch", pci_reset_out_n, 1'h0);
		pg_cmd <= 1'h1;
		while (!pci_reset_out_n && n < 40) begin
			@(posedge aclk);
			n++;
		end
		bound(n);
		chk("isa_rel", isa_reset_drive_out, 1'h0);
		chk("cpu_rel", cpu_reset_out, v);
	endtask
	task automatic t_regs(input logic v);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(RCS_CTRL_ADDR, d, r);
		chk("ctrl_rst", d, RCS_CTRL_RESET);
		axi_wr(RCS_STATUS_ADDR, 32'hffffffff, r);
		chk("st_wr", r, RCS_RESP_OKAY);
		axi_rd(RCS_STATUS_ADDR, d, r);
		chk("status", d, {26'h0, 2'h1, v, v, 2'h3});
		axi_wr(RCS_CTRL_ADDR, 32'h5a5a5a5a, r);
		axi_rd(RCS_CTRL_ADDR, d, r);
		chk("ctrl", d, 32'h5a5a5a5a);
		axi_wr(12'h000, 32'h1, r);
		chk("bad_wr", r, RCS_RESP_SLVERR);
		axi_rd(12'h000, d, r);
		chk("bad_rd", {r, d[29:0]}, {RCS_RESP_SLVERR, 30'h0});
	endtask
	task automatic t_boot(input logic v);
		for (int i = 0; i < 2; i++) begin
			@(posedge aclk);
			mem_addr <= i ? 32'hffff0000 : 32'hfffeffff;
			mem_cycle_valid <= 1'h1;
			@(posedge aclk);
			mem_cycle_valid <= 1'h0;
			@(posedge aclk);
			chk("pos_claim", boot_positive_claim, i[0] && !v);
			chk("sub_claim", boot_subtractive_claim, i[0] && v);
		end
	endtask
	task automatic t_speaker();
		logic [1:0] r;
		logic tp;
		for (int en = 0; en < 2; en++) begin
			axi_wr(RCS_CTRL_ADDR, {30'h0, en[0], 1'h0}, r);
			tp = timer2_out;
			repeat (12) begin
				@(posedge aclk);
				chk("speaker", speaker_out, tp && en[0]);
				tp = timer2_out;
			end
		end
		suspend_pos <= 1'h1;
		@(posedge aclk);
		tp = speaker_out;
		repeat (8) begin
			@(posedge aclk);
			chk("spk_hold", speaker_out, tp);
		end
		suspend_pos <= 1'h0;
		pg_cmd <= 1'h0;
		repeat (6) @(posedge aclk);
		chk("pg_drop", {pci_reset_out_n, speaker_out}, 2'h0);
	endtask
	// Second pass resets in mid-run with the other strap values
	initial begin
		for (int v = 0; v < 2; v++) begin
			t_reset(v[0]);
			t_regs(v[0]);
			t_boot(v[0]);
			t_speaker();
		end
		give_verdict();
	end
endmodule
bind rcs_top rcs_top_chk chk_u (.aclk, .aresetn, .power_good_in, .cpu_type_strap, .boot_decode_strap,
	.timer2_out, .suspend_pos, .init_request, .mem_addr, .mem_cycle_valid, .cpu_reset_out, .cpu_init_out,
	.pci_reset_out_n, .isa_reset_drive_out, .boot_positive_claim, .boot_subtractive_claim, .speaker_out);
`default_nettype wire
